// >>> bench/embedded_multiplier_block_tb.sv
// Bench for the embedded multiplier block, default wide build
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  failures++; $display("MISMATCH %0t result %h", $time, g); end end
module embedded_multiplier_block_tb;
  logic        clk = 1'b0;
  logic        nrst, ena, aclr, go, sign_a, sign_b;
  logic [37:0] cmd;
  logic [17:0] data_a, data_b;
  logic [35:0] result;
  int          failures = 0;
  int          total_checks = 0;
  fabric_src fabric_src_inst(.clk, .go, .cmd, .data_a, .data_b,
    .sign_a, .sign_b);
  embedded_multiplier_block embedded_multiplier_block_inst(.clk, .nrst,
    .ena, .aclr, .data_a, .data_b, .sign_a, .sign_b, .result);
  initial forever #10 clk = ~clk;
  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Fabric edge, input edge, output edge, then look
  task automatic op(input logic [1:0] s, input logic [17:0] a, b,
                    input logic [35:0] e);
    @(posedge clk);
    cmd <= {s, a, b};
    go  <= 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK(result, e)
  endtask
  initial begin
    {nrst, ena, aclr, go, cmd} = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    ena  <= 1'b1;
    op(2'h0, 18'h3FFFF, 18'h3FFFF, 36'hFFFF80001);
    op(2'h3, 18'h3FFFF, 18'h3FFFF, 36'h000000001);
    op(2'h2, 18'h3FFFF, 18'h3FFFF, 36'hFFFFC0001);
    op(2'h1, 18'h3FFFF, 18'h3FFFF, 36'hFFFFC0001);
    op(2'h3, 18'h20000, 18'h20000, 36'h400000000);
    op(2'h2, 18'h3FFFF, 18'h00001, 36'hFFFFFFFFF);
    @(posedge clk);
    ena <= 1'b0;
    op(2'h0, 18'h2, 18'h3, 36'hFFFFFFFFF);
    @(posedge clk);
    ena <= 1'b1;
    op(2'h0, 18'h2, 18'h3, 36'h6);
    @(posedge clk);
    aclr <= 1'b1;
    @(posedge clk);
    #1 `CHK(result, 36'h0)
    @(posedge clk);
    aclr <= 1'b0;
    finish_test();
  end
endmodule

// >>> bench/fabric_src.sv
// Fabric model that launches operands and sign controls
`timescale 1ns/10ps
module fabric_src(
  // Clock and launch request
  input wire logic        clk, go,
  input wire logic [37:0] cmd,
  // Operands and signs toward the block
  output logic [17:0]     data_a, data_b,
  output logic            sign_a, sign_b);
  initial {sign_a, sign_b, data_a, data_b} = '0;
  // One sign per side, shared by both narrow lanes
  always @(posedge clk)
    if (go) {sign_a, sign_b, data_a, data_b} <= cmd;
endmodule

// >>> bench/mult_properties.sv
// Port assertions for the multiplier block, default build
`timescale 1ns/10ps
module mult_chk(
  // Clock and controls
  input wire logic        clk, nrst, ena, aclr, sign_a, sign_b,
  // Data
  input wire logic [17:0] data_a, data_b,
  input wire logic [35:0] result);
  logic [1:0] up_q, e_q;
  wire        v = &e_q;
  function automatic logic [35:0] mul(logic [17:0] a, b, logic sa, sb);
    logic signed [37:0] p;
    p = $signed({sa & a[17], a}) * $signed({sb & b[17], b});
    return p[35:0];
  endfunction
  // Gaps in enable break the two-edge history, so track it
  always_ff @(posedge clk or negedge nrst or posedge aclr)
    if (!nrst || aclr) begin
      up_q <= 2'h0;
      e_q  <= 2'h0;
    end else begin
      e_q  <= {e_q[0], ena};
      up_q <= up_q + {1'b0, ena && up_q != 2'h3};
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst || aclr);
  property p_prod; v |-> result == mul($past(data_a, 2),
    $past(data_b, 2), $past(sign_a, 2), $past(sign_b, 2)); endproperty
  a_prod: assert property (p_prod) else $error("product");
  property p_one; v && $past(data_b, 2) == 18'h1
    |-> result[17:0] == $past(data_a, 2); endproperty
  a_one: assert property (p_one) else $error("unit");
  property p_sign; v && $past(data_a, 2) == 18'h3FFFF
    && $past(data_b, 2) == 18'h1 |-> result[35] == $past(sign_a, 2);
  endproperty
  a_sign: assert property (p_sign) else $error("sign");
  property p_zero; v && $past(data_a, 2) == 18'h0 |-> result == 36'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_hold; !ena |=> $stable(result); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_lat; up_q < 2'h2 |-> result == 36'h0; endproperty
  a_lat: assert property (p_lat) else $error("latency");
  property p_clr; disable iff (1'b0) aclr |-> result == 36'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_rst; disable iff (1'b0) !nrst ##1 !nrst |-> result == 36'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset");
  c_mix: cover property (v && $past(sign_a, 2) != $past(sign_b, 2));
  c_hold: cover property (!ena ##1 ena);
  c_one: cover property (v && $past(data_b, 2) == 18'h1);
endmodule
bind embedded_multiplier_block mult_chk mult_chk_inst(.clk, .nrst, .ena,
  .aclr, .sign_a, .sign_b, .data_a, .data_b, .result);

// >>> hdl/embedded_multiplier_block.sv
// Embedded multiplier block with optional input, sign and output registers
// How it works
// - Product may be registered in 18-bit or 36-bit sections by mode.
// - Each output register has clock, clock enable and async clear.
// - All block registers share one clock, enable and async clear.
// - Exactly two modes: one 18-bit or two independent 9-bit multipliers.
// - Wide mode is one 18x18 multiplier for 10 to 18 bit operands.
// - Wide mode: each operand and product registered or bypassed.
// - Operands signed, unsigned or mixed per the sign controls.
// - Sign controls change at run time; optional dedicated register.
// - Narrow mode gives two independent 9x9 multipliers.
// - Narrow mode: every operand and product independently registered.
// - Narrow multipliers share one A sign and one B sign control.
// - Sign control high means two's complement, low means unsigned.
// - Product signed if any operand signed, else unsigned.
// - Product keeps full precision for all sign settings.
// - Each operand separately chooses its register or bypass.
`timescale 1ns/10ps
`include "mult_defines.svh"
module embedded_multiplier_block #(
  parameter mult_pkg::mode_t MODE = mult_pkg::MODE_WIDE,
  parameter bit REG_A0   = 1'b1,
  parameter bit REG_B0   = 1'b1,
  parameter bit REG_A1   = 1'b1,
  parameter bit REG_B1   = 1'b1,
  parameter bit REG_SA   = 1'b1,
  parameter bit REG_SB   = 1'b1,
  parameter bit REG_OUT0 = 1'b1,
  parameter bit REG_OUT1 = 1'b1
) (
  // Clock, reset and shared register controls
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        ena,
  input  wire logic                        aclr,
  // Operands; wide mode uses the full width of a and b
  input  wire logic [`WIDE_W-1:0]          data_a,
  input  wire logic [`WIDE_W-1:0]          data_b,
  // Sign controls
  input  wire logic                        sign_a,
  input  wire logic                        sign_b,
  // Product; narrow mode puts product 1 in the upper half
  output logic [`WIDE_PROD_W-1:0]          result
);
  localparam int NW = `NARROW_W;
  localparam int NP = `NARROW_PROD_W;

  // Both clears act alike; clear lives with the clock as one shared control
  logic clr_n;
  assign clr_n = nrst & ~aclr;

  // Operand register group
  logic [`WIDE_W-1:0]      a_q;
  logic [`WIDE_W-1:0]      a_d;
  logic [`WIDE_W-1:0]      b_q;
  logic [`WIDE_W-1:0]      b_d;

  // Enable low holds the captured operands, as for every register here
  always_comb begin
    a_d = ena ? data_a : a_q;
    b_d = ena ? data_b : b_q;
  end

  // Clear acts at once, without waiting for a clock edge
  always_ff @(posedge clk or negedge clr_n) begin
    if (!clr_n) begin
      a_q <= '0;
      b_q <= '0;
    end else begin
      a_q <= a_d;
      b_q <= b_d;
    end
  end

  // Sign register group; the controls may change on any cycle
  logic                    sa_q;
  logic                    sa_d;
  logic                    sb_q;
  logic                    sb_d;

  // Held signs keep sign and operand latency equal when both are registered
  always_comb begin
    sa_d = ena ? sign_a : sa_q;
    sb_d = ena ? sign_b : sb_q;
  end

  // A cleared sign register reads as unsigned
  always_ff @(posedge clk or negedge clr_n) begin
    if (!clr_n) begin
      sa_q <= `CLR_VAL;
      sb_q <= `CLR_VAL;
    end else begin
      sa_q <= sa_d;
      sb_q <= sb_d;
    end
  end

  // Register or bypass choices per 9-bit lane, fixed at build time; in wide
  // mode lane 0 settings govern both lanes so the halves stay in step
  localparam bit       WIDE  = (MODE == mult_pkg::MODE_WIDE);

  // Bit 1 is the upper lane or section
  localparam bit [1:0] REG_A = {
    WIDE ? REG_A0 : REG_A1,
    REG_A0
  };
  localparam bit [1:0] REG_B = {
    WIDE ? REG_B0 : REG_B1,
    REG_B0
  };
  localparam bit [1:0] REG_O = {
    WIDE ? REG_OUT0 : REG_OUT1,
    REG_OUT0
  };

  logic [`WIDE_W-1:0]      a_m;
  logic [`WIDE_W-1:0]      b_m;
  logic                    sa_m;
  logic                    sb_m;

  // Signs feed both lanes and the wide multiplier alike
  always_comb begin
    if (REG_SA) begin
      sa_m = sa_q;
    end else begin
      sa_m = sign_a;
    end
    if (REG_SB) begin
      sb_m = sb_q;
    end else begin
      sb_m = sign_b;
    end
  end

  // Operand and sign paths are chosen apart, so a user who mixes them
  // must line up the latencies outside the block; the block itself does
  // not delay one path to match the other
  genvar li;
  generate
    for (li = 0; li < 2; li++) begin : g_in_lane
      // A and B choose their path separately
      assign a_m[li*NW +: NW] =
        REG_A[li] ? a_q[li*NW +: NW] : data_a[li*NW +: NW];
      assign b_m[li*NW +: NW] =
        REG_B[li] ? b_q[li*NW +: NW] : data_b[li*NW +: NW];
    end
  endgenerate

  // Multiplier stage; both sizes are built, the mode keeps one
  logic [`WIDE_PROD_W-1:0] prod_w;
  logic [NP-1:0]           prod_n [2];
  logic [`WIDE_PROD_W-1:0] prod_c;

  // In narrow mode the wide slice is unread and trimmed away
  signed_mult #(.W(`WIDE_W)) u_wide (
    .a      (a_m),
    .b      (b_m),
    .sign_a (sa_m),
    .sign_b (sb_m),
    .prod   (prod_w)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_narrow
      // Both halves see the same sign pair: one A and one B control
      signed_mult #(.W(NW)) u_nar (
        .a      (a_m[gi*NW +: NW]),
        .b      (b_m[gi*NW +: NW]),
        .sign_a (sa_m),
        .sign_b (sb_m),
        .prod   (prod_n[gi])
      );
    end
  endgenerate

  // Mode is a parameter, so only one arm survives in hardware
  always_comb begin
    case (MODE)
      mult_pkg::MODE_WIDE: begin
        prod_c = prod_w;
      end
      mult_pkg::MODE_NARROW: begin
        prod_c = {prod_n[1], prod_n[0]};
      end
      default: begin
        // Unused codes fall back to the wide product
        prod_c = prod_w;
      end
    endcase
  end

  // Output register group, one 18-bit section per lane; in wide mode both
  // sections load together and act as one 36-bit register, while in
  // narrow mode each lane product may be registered on its own
  genvar si;
  generate
    for (si = 0; si < 2; si++) begin : g_out_sec
      logic [NP-1:0] sec_q;
      logic [NP-1:0] sec_d;

      always_comb begin
        sec_d = ena ? prod_c[si*NP +: NP] : sec_q;
      end

      // Clear acts at once, without waiting for a clock edge
      always_ff @(posedge clk or negedge clr_n) begin
        if (!clr_n) begin
          sec_q <= '0;
        end else begin
          sec_q <= sec_d;
        end
      end

      // Bypassed sections pass the product straight through
      assign result[si*NP +: NP] =
        REG_O[si] ? sec_q : prod_c[si*NP +: NP];
    end
  endgenerate
endmodule

// >>> hdl/mult_defines.svh
// Constants for the embedded multiplier block
`ifndef MULT_DEFINES_SVH
`define MULT_DEFINES_SVH
`define WIDE_W       18
`define NARROW_W     9
`define WIDE_PROD_W  36
`define NARROW_PROD_W 18
`define CLR_VAL      1'b0
`endif

// >>> hdl/mult_pkg.sv
// Types for the embedded multiplier block
package mult_pkg;
  typedef enum logic [0:0] {
    MODE_WIDE   = 1'b0,
    MODE_NARROW = 1'b1
  } mode_t;
endpackage

// >>> hdl/signed_mult.sv
// One signed/unsigned full-precision multiplier slice
`timescale 1ns/10ps
module signed_mult #(
  parameter int W = 18
) (
  // Operands
  input  wire logic [W-1:0]   a,
  input  wire logic [W-1:0]   b,
  // Sign controls
  input  wire logic           sign_a,
  input  wire logic           sign_b,
  // Result
  output logic [2*W-1:0]      prod
);
  logic signed [W:0]     a_ext;
  logic signed [W:0]     b_ext;
  logic signed [2*W+1:0] full;

  always_comb begin
    // One extra bit per operand lets one signed multiply cover all cases
    a_ext = {sign_a & a[W-1], a};
    b_ext = {sign_b & b[W-1], b};
    full  = a_ext * b_ext;
    // The low 2W bits hold the exact result in every sign combination
    prod  = full[2*W-1:0];
  end
endmodule
